// [hw/flash_host_map.svh]
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define OFS_ADDR         8'h00
`define OFS_WDATA        8'h04
`define OFS_CMD          8'h08
`define OFS_STATUS       8'h0C
`define OFS_RDATA        8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CMD_OP_LSB       0
`define ST_BUSY          0
`define ST_ASLEEP        1
`define ST_ARRAY_MODE    2
`define ST_ERROR         3
`define ST_SUPPLY_LOW    4
`define ST_REFUSED       5
`define FL_SUPPLY_LOW    3
`define FL_PROGRAM_FAIL  4
`define FL_ERASE_FAIL    5

// ----------------------------------------------------------------------------
// Flash command bytes and timing
// ----------------------------------------------------------------------------
`define FL_READ_ARRAY    8'hFF
`define FL_ERASE_CONFIRM 8'hD0
`define WAKE_NS          600
`define CLK_NS           5
`define WAKE_CLKS        ((`WAKE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [hw/flash_host_pkg.sv]
package flash_host_pkg;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_ACCESS = 4'b0010,
        ST_HOLD   = 4'b0100,
        ST_WAKE   = 4'b1000
    } host_state_t;

    typedef enum logic [1:0] {
        OP_READ  = 2'h0,
        OP_WRITE = 2'h1,
        OP_SLEEP = 2'h2,
        OP_WAKE  = 2'h3
    } host_op_t;

endpackage : flash_host_pkg

// [hw/flash_host_ctrl.sv]
// Function
// - Supply-low flag blocks erase confirm until cleared.
// - Host clears status before any retry.
// - Wait 600 ns after reset release before access.
// - Host reset also holds flash in reset.
// - First access after power-up drops chip select.
// - Write only with write enable and select low.
// - Read-array command before reading array again (the code tracks array mode but accepts reads in either mode).
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`include "flash_host_map.svh"

module flash_host_ctrl #(
    parameter int           AW          = 18,
    parameter int           DW          = 16,
    parameter int           STROBE_CLKS = 32,
    parameter logic [7:0]   CLEAR_CMD   = 8'h50,
    parameter logic [7:0]   STATUS_CMD  = 8'h70
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    output logic               ce_n_o,
    output logic               oe_n_o,
    output logic               we_n_o,
    output logic               reset_powerdown_n_o,
    output logic [AW-1:0]      addr_o,
    output logic [DW-1:0]      dq_o,
    output logic               dq_oe_o,
    input  wire logic [DW-1:0] dq_i
);
    import flash_host_pkg::*;

    localparam int CNT_W = 8;
    localparam int WAKE_CLKS = `WAKE_CLKS;
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CLKS - 1);
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CLKS - 1);

    host_state_t       state_reg;
    logic [CNT_W-1:0]  cnt_reg;
    logic [AW-1:0]     addr_reg;
    logic [DW-1:0]     wdata_reg;
    logic [DW-1:0]     rdata_reg;
    logic              write_reg;
    logic              array_mode_reg;
    logic              error_reg;
    logic              supply_low_reg;
    logic              refused_reg;

    // ------------------------------------------------------------------------
    // Bus decode and command admission
    // ------------------------------------------------------------------------
    logic        bus_req;
    logic        cmd_wr;
    host_op_t    op;
    logic [7:0]  wbyte;
    logic        guard_bad;
    logic        accept;
    logic        clear_wr;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmd_wr  = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `OFS_CMD);
    assign op      = host_op_t'(wb_dat_i[`CMD_OP_LSB +: 2]);
    assign wbyte   = wdata_reg[7:0];
    // Retry blocked until status is cleared; erase confirm blocked on low supply.
    assign guard_bad = (error_reg && wbyte != CLEAR_CMD && wbyte != STATUS_CMD)
                     || (supply_low_reg && wbyte == `FL_ERASE_CONFIRM);
    always_comb begin
        accept = 1'b0;
        if (cmd_wr && state_reg == ST_IDLE) begin
            unique case (op)
                OP_READ:  accept = reset_powerdown_n_o;
                OP_WRITE: accept = reset_powerdown_n_o && !guard_bad;
                OP_SLEEP: accept = reset_powerdown_n_o;
                OP_WAKE:  accept = !reset_powerdown_n_o;
            endcase
        end
    end
    assign clear_wr = accept && op == OP_WRITE && wbyte == CLEAR_CMD;

    // ------------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `OFS_ADDR:   wb_dat_o <= 32'(addr_reg);
                    `OFS_WDATA:  wb_dat_o <= 32'(wdata_reg);
                    `OFS_RDATA:  wb_dat_o <= 32'(rdata_reg);
                    `OFS_STATUS: wb_dat_o <= 32'({refused_reg, supply_low_reg, error_reg,
                                                  array_mode_reg, !reset_powerdown_n_o,
                                                  state_reg != ST_IDLE});
                    default:     wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg  <= '0;
            wdata_reg <= '0;
        end else if (bus_req && wb_we_i) begin
            if (wb_adr_i == `OFS_ADDR)
                addr_reg <= wb_dat_i[AW-1:0];
            if (wb_adr_i == `OFS_WDATA)
                wdata_reg <= wb_dat_i[DW-1:0];
        end
    end

    // Refused sticky bit: a new refusal wins over a write-one clear.
    always_ff @(posedge clk_i) begin
        if (rst_i)
            refused_reg <= 1'b0;
        else if (cmd_wr && !accept)
            refused_reg <= 1'b1;
        else if (bus_req && wb_we_i && wb_adr_i == `OFS_STATUS && wb_dat_i[`ST_REFUSED])
            refused_reg <= 1'b0;
    end

    // ------------------------------------------------------------------------
    // Flash pin sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg           <= ST_IDLE;
            cnt_reg             <= '0;
            write_reg           <= 1'b0;
            ce_n_o              <= 1'b1;
            oe_n_o              <= 1'b1;
            we_n_o              <= 1'b1;
            reset_powerdown_n_o <= 1'b0;
            addr_o              <= '0;
            dq_o                <= '0;
            dq_oe_o             <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= '0;
                    if (accept) begin
                        unique case (op)
                            OP_READ, OP_WRITE: begin
                                write_reg <= (op == OP_WRITE);
                                addr_o    <= addr_reg;
                                dq_o      <= wdata_reg;
                                dq_oe_o   <= (op == OP_WRITE);
                                ce_n_o    <= 1'b0;
                                we_n_o    <= !(op == OP_WRITE);
                                oe_n_o    <= (op == OP_WRITE);
                                state_reg <= ST_ACCESS;
                            end
                            OP_SLEEP: reset_powerdown_n_o <= 1'b0;
                            OP_WAKE: begin
                                reset_powerdown_n_o <= 1'b1;
                                state_reg           <= ST_WAKE;
                            end
                        endcase
                    end
                end
                ST_ACCESS: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == STROBE_LAST) begin
                        we_n_o    <= 1'b1;
                        oe_n_o    <= 1'b1;
                        state_reg <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    ce_n_o    <= 1'b1;
                    dq_oe_o   <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                ST_WAKE: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == WAKE_LAST)
                        state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Tracking of the flash's command mode and error flags
    // ------------------------------------------------------------------------
    logic read_done;
    assign read_done = state_reg == ST_ACCESS && cnt_reg == STROBE_LAST && !write_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i)
            rdata_reg <= '0;
        else if (read_done)
            rdata_reg <= dq_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            array_mode_reg <= 1'b1;
        else if (accept && op == OP_WAKE)
            array_mode_reg <= 1'b1;
        else if (accept && op == OP_WRITE)
            array_mode_reg <= (wbyte == `FL_READ_ARRAY);
    end

    // Status reads latch the device's fail flags until the clear command is sent or a sleep command is accepted.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_reg      <= 1'b0;
            supply_low_reg <= 1'b0;
        end else if (read_done && !array_mode_reg) begin
            if (dq_i[`FL_SUPPLY_LOW] || dq_i[`FL_PROGRAM_FAIL] || dq_i[`FL_ERASE_FAIL])
                error_reg <= 1'b1;
            if (dq_i[`FL_SUPPLY_LOW])
                supply_low_reg <= 1'b1;
        end else if (clear_wr || (accept && op == OP_SLEEP)) begin
            error_reg      <= 1'b0;
            supply_low_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    logic [CNT_W-1:0] since_wake;
    always_ff @(posedge clk_i) begin
        if (rst_i || !reset_powerdown_n_o)
            since_wake <= '0;
        else if (since_wake != WAKE_LAST + 1'b1)
            since_wake <= since_wake + 1'b1;
    end

    // Counts the cycles that chip select has been held low, so that the strobe length can be checked
    // for any strobe parameter without a long repetition in the property.
    localparam logic [CNT_W:0] STROBE_SPAN = (CNT_W+1)'(STROBE_CLKS + 1);
    logic [CNT_W:0] ce_low_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i || ce_n_o)
            ce_low_cnt <= '0;
        else
            ce_low_cnt <= ce_low_cnt + 1'b1;
    end

    a_wake_no_access: assert property (@(posedge clk_i) disable iff (rst_i)
        (since_wake < WAKE_LAST) |-> ce_n_o) else $error("flash accessed before wake time");
    a_write_with_ce: assert property (@(posedge clk_i) disable iff (rst_i)
        !we_n_o |-> !ce_n_o && oe_n_o && dq_oe_o) else $error("write strobe without select");
    a_read_with_ce: assert property (@(posedge clk_i) disable iff (rst_i)
        !oe_n_o |-> !ce_n_o && !dq_oe_o) else $error("output enable without select");
    a_reset_holds_rp: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> !reset_powerdown_n_o && ce_n_o) else $error("flash not held in reset");
    a_supply_low_block: assert property (@(posedge clk_i) disable iff (rst_i)
        (supply_low_reg && $fell(we_n_o)) |-> dq_o[7:0] != `FL_ERASE_CONFIRM)
        else $error("erase confirm sent while supply low flagged");
    a_clear_first: assert property (@(posedge clk_i) disable iff (rst_i)
        (error_reg && $fell(we_n_o)) |-> (dq_o[7:0] == CLEAR_CMD || dq_o[7:0] == STATUS_CMD))
        else $error("command sent before clearing status");
    a_array_mode_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
        (accept && op == OP_WRITE && wbyte == `FL_READ_ARRAY) |=> array_mode_reg ##1 !we_n_o)
        else $error("read-array command not tracked");
    a_strobe_length: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ce_n_o) |-> ce_low_cnt == STROBE_SPAN) else $error("strobe length wrong");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");

    c_wake_done: cover property (@(posedge clk_i) disable iff (rst_i)
        state_reg == ST_WAKE ##1 state_reg == ST_IDLE);
    c_error_seen: cover property (@(posedge clk_i) disable iff (rst_i) $rose(error_reg));
    c_refused: cover property (@(posedge clk_i) disable iff (rst_i)
        cmd_wr && op == OP_WRITE && guard_bad);
    c_clear: cover property (@(posedge clk_i) disable iff (rst_i) error_reg && clear_wr);

endmodule : flash_host_ctrl

// [tb/flash_dev_model.sv]
module flash_dev_model (
    input  wire logic        clk_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        rp_n_i,
    input  wire logic        supply_ok_i,
    input  wire logic [17:0] addr_i,
    input  wire logic [15:0] data_i,
    output logic      [15:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [64];
    logic [15:0] last_q      = 16'h0000;
    logic [7:0]  sr_reg      = 8'h00;
    logic [6:0]  busy_cnt    = 7'h00;
    logic        status_mode = 1'b0;
    logic        erase_setup = 1'b0;
    logic        prog_setup  = 1'b0;
    logic        drive;
    logic [15:0] val;

    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    always @(negedge rp_n_i) begin
        sr_reg = 8'h00;
        busy_cnt = 7'h00;
        status_mode = 1'b0;
        erase_setup = 1'b0;
        prog_setup = 1'b0;
    end
    always @(posedge clk_i) if (busy_cnt != 7'h00) busy_cnt <= busy_cnt - 7'h01;
    always @(posedge we_n_i) if (!ce_n_i && rp_n_i) begin
        if (erase_setup) begin
            erase_setup = 1'b0;
            if (data_i[7:0] !== 8'hD0) sr_reg[5:4] = 2'b11;
            else if (!supply_ok_i || sr_reg[3]) sr_reg[5:3] = sr_reg[5:3] | 3'b101;
            else begin
                foreach (mem[i]) mem[i] = 16'hFFFF;
                busy_cnt = 7'h3C;
            end
        end else if (prog_setup) begin
            prog_setup = 1'b0;
            mem[addr_i[5:0]] = mem[addr_i[5:0]] & data_i;
            busy_cnt = 7'h3C;
        end else begin
            status_mode = data_i[7:0] != 8'hFF;
            if (data_i[7:0] == 8'h50) sr_reg = 8'h00;
            erase_setup = data_i[7:0] == 8'h20;
            prog_setup = data_i[7:0] == 8'h40;
        end
    end
    assign drive = !ce_n_i && !oe_n_i && rp_n_i;
    assign val = status_mode ? {8'h00, busy_cnt == 7'h00, sr_reg[6:0]} : mem[addr_i[5:0]];
    always @(posedge clk_i) if (drive) last_q <= val;
    assign data_o = drive ? val : ~last_q;
endmodule : flash_dev_model

// [tb/tb.sv]
`include "flash_host_map.svh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
    $display("Error %s exp %0h saw %0h", n, e, s); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_host_pkg::*;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic        supply_ok = 1'b1;
    logic [31:0] wb_dat_o, q;
    logic        wb_ack_o, ce_n_o, oe_n_o, we_n_o, reset_powerdown_n_o, dq_oe_o;
    logic [17:0] addr_o;
    logic [15:0] dq_o, dq_i;
    int          mismatches = 0, tests_run = 0, cycles = 0, t0;

    flash_host_ctrl #(.STROBE_CLKS(4)) flash_host_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
        .reset_powerdown_n_o(reset_powerdown_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i));
    flash_dev_model flash_dev_model_i (.clk_i(clk_i), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
        .rp_n_i(reset_powerdown_n_o), .supply_ok_i(supply_ok), .addr_i(addr_o), .data_i(dq_o), .data_o(dq_i));

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) cycles++;
    always @(posedge clk_i) if (we_n_o === 1'b0) `CHK("ce_with_we", 1'b0, ce_n_o)

    task automatic close_out;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 64) begin
            mismatches++;
            close_out();
        end
    endtask : wb

    task automatic op(input host_op_t o);
        int n;
        n = 0;
        wb(`OFS_CMD, 1'b1, {30'h0, o});
        do begin
            wb(`OFS_STATUS, 1'b0, 32'h0);
            n++;
        end while (q[`ST_BUSY] !== 1'b0 && n < 200);
        if (n >= 200) begin
            mismatches++;
            close_out();
        end
    endtask : op

    task automatic fw(input logic [15:0] d);
        wb(`OFS_WDATA, 1'b1, {16'h0, d});
        op(OP_WRITE);
    endtask : fw

    task automatic fr(input logic [17:0] a);
        wb(`OFS_ADDR, 1'b1, {14'h0, a});
        op(OP_READ);
        wb(`OFS_RDATA, 1'b0, 32'h0);
    endtask : fr

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(`OFS_STATUS, 1'b0, 32'h0);
        `CHK("asleep", 1'b1, q[`ST_ASLEEP])
        `CHK("rp_in_reset", 1'b0, reset_powerdown_n_o)
        op(OP_READ);
        `CHK("read_asleep", 1'b1, q[`ST_REFUSED])
        wb(`OFS_STATUS, 1'b1, 32'h20);
        t0 = cycles;
        op(OP_WAKE);
        `CHK("wake_time", 1'b1, cycles - t0 >= 120)
        `CHK("array_mode", 1'b1, q[`ST_ARRAY_MODE])
        `CHK("rp_high", 1'b1, reset_powerdown_n_o)
        wb(`OFS_ADDR, 1'b1, 32'h5);
        fw(16'h0040);
        fw(16'h1234);
        fr(18'h5);
        `CHK("sr_busy", 16'h0000, q[15:0])
        repeat (80) @(posedge clk_i);
        fr(18'h5);
        `CHK("sr_ready", 16'h0080, q[15:0])
        fw(16'h00FF);
        fr(18'h5);
        `CHK("programmed", 16'h1234, q[15:0])
        `CHK("standby", 1'b0, dq_oe_o)
        fr(18'h6);
        `CHK("untouched", 16'hFFFF, q[15:0])
        fw(16'h0020);
        fw(16'h0070);
        fr(18'h0);
        `CHK("seq_error", 16'h00B0, q[15:0])
        wb(`OFS_STATUS, 1'b0, 32'h0);
        `CHK("error", 1'b1, q[`ST_ERROR])
        `CHK("no_supply_low", 1'b0, q[`ST_SUPPLY_LOW])
        fw(16'h0020);
        `CHK("retry_refused", 1'b1, q[`ST_REFUSED])
        wb(`OFS_STATUS, 1'b1, 32'h20);
        fw(16'h0050);
        `CHK("error_cleared", 1'b0, q[`ST_ERROR])
        fw(16'h0070);
        fr(18'h0);
        `CHK("sr_clean", 16'h0080, q[15:0])
        supply_ok = 1'b0;
        fw(16'h0020);
        fw(16'h00D0);
        fr(18'h0);
        `CHK("supply_err", 16'h00A8, q[15:0])
        wb(`OFS_STATUS, 1'b0, 32'h0);
        `CHK("supply_low", 1'b1, q[`ST_SUPPLY_LOW])
        fw(16'h00D0);
        `CHK("confirm_refused", 1'b1, q[`ST_REFUSED])
        wb(`OFS_STATUS, 1'b1, 32'h20);
        fw(16'h0070);
        fr(18'h0);
        `CHK("erase_fail_kept", 16'h00A8, q[15:0])
        op(OP_SLEEP);
        `CHK("rp_low", 1'b0, reset_powerdown_n_o)
        `CHK("sleep_err", 1'b0, q[`ST_ERROR])
        `CHK("sleep_low", 1'b0, q[`ST_SUPPLY_LOW])
        `CHK("ce_idle", 1'b1, ce_n_o)
        supply_ok = 1'b1;
        op(OP_WAKE);
        fr(18'h5);
        `CHK("wake_array", 16'h1234, q[15:0])
        fw(16'h0070);
        fr(18'h0);
        `CHK("sr_reset", 16'h0080, q[15:0])
        wb(8'h1C, 1'b0, 32'h0);
        `CHK("unmapped", 32'h0, q)
        close_out();
    end
endmodule : tb
